//--- pkg/hwv_pkg.sv
// Shared constants and types for the widget verb responder.
// Assumes verbs arrive already deframed, one per valid pulse.
package hwv_pkg;

    // Node identifiers
    localparam logic [7:0] NID_ROOT     = 8'h00;
    localparam logic [7:0] NID_FUNC     = 8'h01;
    localparam logic [7:0] NID_SPDIF    = 8'h02;
    localparam logic [7:0] NID_FRONT    = 8'h03;
    localparam logic [7:0] NID_OUT_LAST = 8'h05;
    localparam logic [7:0] NID_ADC      = 8'h06;
    localparam logic [7:0] NID_MIX_1ST  = 8'h07;
    localparam logic [7:0] NID_DOWNMIX  = 8'h09;
    localparam logic [7:0] NID_SEL_1ST  = 8'h0A;
    localparam logic [7:0] NID_MICSEL   = 8'h0F;
    localparam logic [7:0] NID_LINESEL  = 8'h10;
    localparam logic [7:0] NID_MICSWAP  = 8'h11;
    localparam logic [7:0] NID_RECSEL   = 8'h12;
    localparam logic [7:0] NID_SEL_LAST = 8'h18;
    localparam logic [7:0] NID_BEEP     = 8'h19;
    localparam logic [7:0] NID_HP       = 8'h1A;

    // Widget type codes
    localparam logic [3:0] WT_OUT   = 4'h0;
    localparam logic [3:0] WT_IN    = 4'h1;
    localparam logic [3:0] WT_MIX   = 4'h2;
    localparam logic [3:0] WT_SEL   = 4'h3;
    localparam logic [3:0] WT_PIN   = 4'h4;
    localparam logic [3:0] WT_BEEP  = 4'h7;
    localparam logic [3:0] WT_NONE  = 4'hF;

    // 12-bit verb identifiers
    localparam logic [11:0] V_GET_SDI   = 12'hF04;
    localparam logic [11:0] V_SET_SDI   = 12'h704;
    localparam logic [11:0] V_GET_PST   = 12'hF03;
    localparam logic [11:0] V_SET_PST   = 12'h703;
    localparam logic [11:0] V_GET_PARAM = 12'hF00;
    // 4-bit verb identifiers (16-bit payload)
    localparam logic [3:0]  V4_GET_COEF = 4'hC;
    localparam logic [3:0]  V4_SET_COEF = 4'h4;
    localparam logic [3:0]  V4_GET_CIDX = 4'hD;
    localparam logic [3:0]  V4_SET_CIDX = 4'h5;
    localparam logic [3:0]  V4_GET_AMP  = 4'hB;
    localparam logic [3:0]  V4_SET_AMP  = 4'h3;
    localparam logic [7:0]  PARAM_WCAP  = 8'h09;

    // Processing state fields
    localparam int          PST_SYMMETRY_BIT = 7;
    localparam logic [6:0]  PST_EQ_OFF  = 7'h00;
    localparam logic [6:0]  PST_EQ_BEN  = 7'h01;
    localparam logic [6:0]  PST_EQ_ON   = 7'h02;
    localparam logic [7:0]  PST_RESET   = 8'h00;

    // Amplifier payload fields
    localparam int          AMP_GET_OUT = 15;
    localparam int          AMP_SET_OUT = 15;
    localparam int          AMP_SET_IN  = 14;
    localparam int          AMP_MUTE    = 7;
    localparam logic [3:0]  AMP_IDX_SUR = 4'h0;
    localparam logic [3:0]  AMP_IDX_CLF = 4'h1;
    localparam int          WCAP_TYPE_LSB = 20;

    localparam logic [31:0] RESP_ZERO   = 32'h0000_0000;

    // A verb as it arrives: node and 20-bit verb field
    typedef struct packed {
        logic [7:0]  nid;
        logic [19:0] verb;
    } hwv_cmd_s;

endpackage

//--- logic/hwv_coef_ram.sv
// Coefficient store: 256 words of 16 bits, registered read.
// Assumes one clock; write and read addresses are the same index.
`timescale 1ns/1ns
`default_nettype none
module hwv_coef_ram #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input  wire logic          i_clk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Widths must be usable
    if (AW < 1 || DW < 1)
    begin : g_bad
        $error("Store address and data widths must be positive");
    end

    // Write port and registered read
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule
`default_nettype wire

//--- logic/hwv_responder.sv
// Widget verb decoder and responder for the codec audio function.
// Assumes verbs are presented one at a time with a one-cycle valid.
// How it works
// - SDI select sets ignored, gets return zero
// - Coefficient verbs access word at current index
// - Index is eight bits, never auto-increments
// - Root and function ignore processing state
// - Front state: EQ low bits, symmetry bit 7
// - Downmix mutes only on input zero, output
// - Downmix input one mute ignored, reads zero
// - Mic swap ignores coefficient and index verbs
// - Mic swap state zero off, else up-mix
// - Up-mix drives both outputs from left
// - Mic swap exchanges front mic left/right
// - Node zero root, node one audio function
// - Nodes two to five are audio outputs
// - Node six is the record input
// - Digital output picks link or record stream
// - Nodes seven to nine are mixers
// - Nodes 0x0A to 0x18 are selectors
// - Mic selector picks front mic or centre
// - Line-in selector picks line, surround, mic
// - Node 0x19 is the beep generator
// - Node 0x1A is the headphone pin
`timescale 1ns/1ns
`default_nettype none
module hwv_responder
    import hwv_pkg::*;
#(
    parameter int CIDX_W = 8,
    parameter int COEF_W = 16
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RSTN,
    input  wire logic              I_CMD_VALID,
    input  wire hwv_pkg::hwv_cmd_s I_CMD,
    input  wire logic              I_SPDIF_SRC_REC,
    input  wire logic [1:0]        I_MIC_SEL,
    input  wire logic [1:0]        I_LINE_SEL,
    input  wire logic              I_MIC_SWAP,
    input  wire logic              I_MIC_L,
    input  wire logic              I_MIC_R,
    output logic                   O_RESP_VALID,
    output logic      [31:0]       O_RESP,
    output logic                   O_EQ_ENABLE_INVERTED,
    output logic                   O_COEFF_SYMMETRY,
    output logic                   O_UPMIX_EN,
    output logic                   O_SURR_MUTE,
    output logic                   O_DMX_OUT_MUTE,
    output logic                   O_MIC_OUT_L,
    output logic                   O_MIC_OUT_R,
    output logic                   O_SPDIF_SRC_REC,
    output logic      [1:0]        O_MIC_SRC,
    output logic      [1:0]        O_LINE_SRC
);

    // ************************************************
    // Parameter check
    // ************************************************
    if (CIDX_W != 8 || COEF_W != 16)
    begin : g_bad
        $error("Coefficient index must be 8 bits and words 16 bits");
    end

    // ************************************************
    // Verb decode
    // ************************************************
    logic [7:0]  nid;
    logic [11:0] v12;
    logic [3:0]  v4;
    logic [15:0] pay16;
    logic [7:0]  pay8;
    logic        on_root;
    logic        on_front;
    logic        on_swap;
    logic        on_dmx;

    // Field extraction
    assign nid      = I_CMD.nid;
    assign v12      = I_CMD.verb[19:8];
    assign v4       = I_CMD.verb[19:16];
    assign pay16    = I_CMD.verb[15:0];
    assign pay8     = I_CMD.verb[7:0];
    assign on_root  = (nid == NID_ROOT) || (nid == NID_FUNC);
    assign on_front = (nid == NID_FRONT);
    assign on_swap  = (nid == NID_MICSWAP);
    assign on_dmx   = (nid == NID_DOWNMIX);

    // Coefficient paths live on the front DAC only; swap refuses them
    logic set_cidx;
    logic get_cidx;
    logic set_coef;
    logic get_coef;
    logic set_pst;
    logic get_pst;
    logic set_amp;
    logic get_amp;
    logic get_wcap;

    assign set_cidx = I_CMD_VALID && on_front && v4 == V4_SET_CIDX;
    assign get_cidx = I_CMD_VALID && on_front && v4 == V4_GET_CIDX;
    assign set_coef = I_CMD_VALID && on_front && v4 == V4_SET_COEF;
    assign get_coef = I_CMD_VALID && on_front && v4 == V4_GET_COEF;
    assign set_pst  = I_CMD_VALID && (on_front || on_swap) && v12 == V_SET_PST;
    assign get_pst  = I_CMD_VALID && v12 == V_GET_PST;
    assign set_amp  = I_CMD_VALID && on_dmx && v4 == V4_SET_AMP;
    assign get_amp  = I_CMD_VALID && on_dmx && v4 == V4_GET_AMP;
    assign get_wcap = I_CMD_VALID && v12 == V_GET_PARAM && pay8 == PARAM_WCAP;

    // ************************************************
    // Coefficient index and store
    // ************************************************
    logic [CIDX_W-1:0] cidx_r;
    logic [COEF_W-1:0] coef_rd;

    // Index changes only on its own set verb
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            cidx_r <= '0;
        end
        else if (set_cidx)
        begin
            cidx_r <= pay16[CIDX_W-1:0];
        end
    end

    hwv_coef_ram #(
        .AW (CIDX_W),
        .DW (COEF_W)
    ) u_coef (
        .i_clk   (I_CLK),
        .i_we    (set_coef),
        .i_addr  (cidx_r),
        .i_wdata (pay16[COEF_W-1:0]),
        .o_rdata (coef_rd)
    );

    // ************************************************
    // Processing states
    // ************************************************
    logic [7:0] front_pst_r;
    logic [7:0] swap_pst_r;
    logic [6:0] eq_req;
    logic [7:0] pst_store;

    // Requested on state collapses to benign
    assign eq_req    = pay8[6:0];
    assign pst_store = {pay8[PST_SYMMETRY_BIT],
                        (eq_req == PST_EQ_ON) ? PST_EQ_BEN : eq_req};

    // Front DAC state
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            front_pst_r <= PST_RESET;
        end
        else if (set_pst && on_front)
        begin
            front_pst_r <= pst_store;
        end
    end

    // Mic swap state
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            swap_pst_r <= PST_RESET;
        end
        else if (set_pst && on_swap)
        begin
            swap_pst_r <= {1'b0, (eq_req == PST_EQ_ON) ? PST_EQ_BEN : eq_req};
        end
    end

    // Equalizer control: off only when low bits are zero
    assign O_EQ_ENABLE_INVERTED = (front_pst_r[6:0] == PST_EQ_OFF);
    assign O_COEFF_SYMMETRY     = ~front_pst_r[PST_SYMMETRY_BIT];
    assign O_UPMIX_EN           = (swap_pst_r[6:0] != PST_EQ_OFF);

    // ************************************************
    // Downmix amplifier mutes
    // ************************************************
    logic surr_mute_r;
    logic out_mute_r;

    // Only the surround input and the output keep a mute
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            surr_mute_r <= 1'b0;
            out_mute_r  <= 1'b0;
        end
        else if (set_amp)
        begin
            if (pay16[AMP_SET_IN] && pay16[11:8] == AMP_IDX_SUR)
            begin
                surr_mute_r <= pay16[AMP_MUTE];
            end
            if (pay16[AMP_SET_OUT])
            begin
                out_mute_r <= pay16[AMP_MUTE];
            end
        end
    end

    assign O_SURR_MUTE    = surr_mute_r;
    assign O_DMX_OUT_MUTE = out_mute_r;

    // ************************************************
    // Widget types
    // ************************************************
    logic [3:0] wtype;

    // Node number to widget type
    always_comb
    begin
        if (nid >= NID_SPDIF && nid <= NID_OUT_LAST)
            wtype = WT_OUT;
        else if (nid == NID_ADC)
            wtype = WT_IN;
        else if (nid >= NID_MIX_1ST && nid <= NID_DOWNMIX)
            wtype = WT_MIX;
        else if (nid >= NID_SEL_1ST && nid <= NID_SEL_LAST)
            wtype = WT_SEL;
        else if (nid == NID_BEEP)
            wtype = WT_BEEP;
        else if (nid == NID_HP)
            wtype = WT_PIN;
        else
            wtype = WT_NONE;
    end

    // ************************************************
    // Response
    // ************************************************
    logic [31:0] resp_nxt;
    logic        coef_pend_r;

    // Answer value for all verbs except coefficient reads
    always_comb
    begin
        resp_nxt = RESP_ZERO;
        if (get_pst && (on_front || on_swap))
            resp_nxt = {24'h0, on_front ? front_pst_r : swap_pst_r};
        else if (get_cidx)
            resp_nxt = {24'h0, cidx_r};
        else if (get_amp && pay16[AMP_GET_OUT])
            resp_nxt = {24'h0, out_mute_r, 7'h00};
        else if (get_amp && pay16[3:0] == AMP_IDX_SUR)
            resp_nxt = {24'h0, surr_mute_r, 7'h00};
        else if (get_wcap && !on_root && wtype != WT_NONE)
            resp_nxt = {8'h0, wtype, 20'h0};
    end

    // Coefficient reads answer one cycle later, after the store read
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            coef_pend_r  <= 1'b0;
            O_RESP_VALID <= 1'b0;
            O_RESP       <= RESP_ZERO;
        end
        else
        begin
            coef_pend_r  <= get_coef;
            O_RESP_VALID <= (I_CMD_VALID && !get_coef) || coef_pend_r;
            if (coef_pend_r)
                O_RESP <= {16'h0, coef_rd};
            else if (I_CMD_VALID)
                O_RESP <= resp_nxt;
        end
    end

    // ************************************************
    // Routing controls
    // ************************************************
    // Swap then optional left spread
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_MIC_OUT_L     <= 1'b0;
            O_MIC_OUT_R     <= 1'b0;
            O_SPDIF_SRC_REC <= 1'b0;
            O_MIC_SRC       <= 2'b00;
            O_LINE_SRC      <= 2'b00;
        end
        else
        begin
            O_MIC_OUT_L     <= I_MIC_SWAP ? I_MIC_R : I_MIC_L;
            O_MIC_OUT_R     <= O_UPMIX_EN ? (I_MIC_SWAP ? I_MIC_R : I_MIC_L)
                                          : (I_MIC_SWAP ? I_MIC_L : I_MIC_R);
            O_SPDIF_SRC_REC <= I_SPDIF_SRC_REC;
            O_MIC_SRC       <= I_MIC_SEL;
            O_LINE_SRC      <= I_LINE_SEL;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_sdi_zero;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (I_CMD_VALID && I_CMD.verb[19:8] == V_GET_SDI) |=> (O_RESP == RESP_ZERO);
    endproperty
    a_sdi_zero: assert property (p_sdi_zero) else $error("SDI get not zero");

    property p_root_pst;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (I_CMD_VALID && on_root && v12 == V_GET_PST) |=> (O_RESP == RESP_ZERO);
    endproperty
    a_root_pst: assert property (p_root_pst) else $error("Root state not zero");

    property p_idx_hold;
        @(posedge I_CLK) disable iff (!I_RSTN)
        set_coef |=> $stable(cidx_r);
    endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("Index moved");

    sequence s_coef_write;
        set_coef ##1 set_cidx ##1 (get_coef && cidx_r == $past(cidx_r, 2));
    endsequence
    property p_coef_back;
        logic [15:0] d;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (s_coef_write, d = $past(pay16, 2)) |-> ##2 (O_RESP_VALID && O_RESP[15:0] == d);
    endproperty
    a_coef_back: assert property (p_coef_back) else $error("Coefficient lost");

    property p_on_benign;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (set_pst && on_front && eq_req == PST_EQ_ON) |=> (front_pst_r[6:0] == PST_EQ_BEN);
    endproperty
    a_on_benign: assert property (p_on_benign) else $error("On not benign");

    property p_center_sub_zero;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (get_amp && !pay16[AMP_GET_OUT] && pay16[3:0] == AMP_IDX_CLF) |=> (O_RESP == RESP_ZERO);
    endproperty
    a_center_sub_zero: assert property (p_center_sub_zero) else $error("Centre mute read");

    property p_swap_cidx;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (I_CMD_VALID && on_swap && v4 == V4_SET_CIDX) |=> $stable(cidx_r);
    endproperty
    a_swap_cidx: assert property (p_swap_cidx) else $error("Swap changed index");

    property p_upmix;
        @(posedge I_CLK) disable iff (!I_RSTN)
        (O_UPMIX_EN && $stable(O_UPMIX_EN)) |=> (O_MIC_OUT_L == O_MIC_OUT_R);
    endproperty
    a_upmix: assert property (p_upmix) else $error("Up-mix outputs differ");

endmodule
`default_nettype wire

//--- tb/hwv_ctl_model.sv
// Bus controller model: issues one verb at a time and collects its answer.
// Assumes the responder answers within four cycles of taking a verb.
`timescale 1ns/1ns
`default_nettype none
module hwv_ctl_model
    import hwv_pkg::*;
(
    input  wire logic              i_clk,
    output var  logic              o_cmd_valid,
    output var  hwv_pkg::hwv_cmd_s o_cmd,
    input  wire logic              i_resp_valid,
    input  wire logic [31:0]       i_resp
);
    // Idle command lines at time zero
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd       = '0;
    end

    // One verb, then a bounded wait for its answer; entered at a falling edge
    task automatic xfer(input logic [7:0] nid, input logic [19:0] verb,
                        output logic [31:0] resp, output logic ok);
        int i;
        ok          = 1'b0;
        resp        = RESP_ZERO;
        o_cmd_valid = 1'b1;
        o_cmd       = {nid, verb};
        for (i = 0; i < 4 && !ok; i++)
        begin
            @(negedge i_clk);
            // Released lines show the inverse, never a held copy
            if (i == 0)
            begin
                o_cmd_valid = 1'b0;
                o_cmd       = ~o_cmd;
            end
            if (i_resp_valid === 1'b1)
            begin
                resp = i_resp;
                ok   = 1'b1;
            end
        end
        // Let an edge pass so valid is not raised again in the same step
        @(negedge i_clk);
    endtask

    // Index is rewritten before each coefficient access, as it never steps
    task automatic coef(input logic [7:0] nid, input logic [7:0] idx,
                        input logic [19:0] verb, output logic [31:0] resp,
                        output logic ok);
        xfer(nid, {V4_SET_CIDX, 8'h00, idx}, resp, ok);
        if (ok)
            xfer(nid, verb, resp, ok);
    endtask

    // Four verbs on consecutive edges; only the last answer is kept
    task automatic burst(input logic [7:0] nid, input logic [19:0] v1,
                         input logic [19:0] v2, input logic [19:0] v3,
                         input logic [19:0] v4, output logic [31:0] resp,
                         output logic ok);
        o_cmd_valid = 1'b1;
        o_cmd       = {nid, v1};
        @(negedge i_clk);
        o_cmd       = {nid, v2};
        @(negedge i_clk);
        o_cmd       = {nid, v3};
        @(negedge i_clk);
        xfer(nid, v4, resp, ok);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the widget verb responder.
// Assumes the controller model drives verbs; pin inputs are driven here.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import hwv_pkg::*;
    logic        clk, rstn, spdif, swap, mic_l, mic_r, rv, eqi, symmetric;
    logic        upm, smute, omute, ml, mr, spo, cv, ok, sel_l;
    logic [1:0]  msel, lsel, mso, lso;
    logic [7:0]  c, e;
    logic [31:0] resp, r;
    hwv_cmd_s    cmd;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          i;
    logic [7:0]  codes [6]  = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h81, 8'h82};

    hwv_responder dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_CMD_VALID(cv), .I_CMD(cmd),
        .I_SPDIF_SRC_REC(spdif), .I_MIC_SEL(msel), .I_LINE_SEL(lsel),
        .I_MIC_SWAP(swap), .I_MIC_L(mic_l), .I_MIC_R(mic_r), .O_RESP_VALID(rv),
        .O_RESP(resp), .O_EQ_ENABLE_INVERTED(eqi), .O_COEFF_SYMMETRY(symmetric),
        .O_UPMIX_EN(upm), .O_SURR_MUTE(smute), .O_DMX_OUT_MUTE(omute),
        .O_MIC_OUT_L(ml), .O_MIC_OUT_R(mr), .O_SPDIF_SRC_REC(spo),
        .O_MIC_SRC(mso), .O_LINE_SRC(lso));

    hwv_ctl_model ctl_u (.i_clk(clk), .o_cmd_valid(cv), .o_cmd(cmd),
        .i_resp_valid(rv), .i_resp(resp));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Counts, verdict and end of run
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // Answer arrived in time and carries the expected word
    task automatic done(input logic [31:0] exp);
        if (!ok)
        begin
            chk("answer_ok", ok, 32'h1);
            report_and_stop();
        end
        else
        begin
            chk("resp", r, exp);
        end
    endtask

    // Plain verb, and coefficient access with index rewrite
    task automatic x(input logic [7:0] n, input logic [19:0] v, input logic [31:0] exp);
        ctl_u.xfer(n, v, r, ok);
        done(exp);
    endtask

    task automatic cf(input logic [7:0] n, input logic [7:0] idx, input logic [19:0] v,
                      input logic [31:0] exp);
        ctl_u.coef(n, idx, v, r, ok);
        done(exp);
    endtask

    // Widget type word that a node should report
    function automatic logic [31:0] exp_wcap(input logic [7:0] n);
        logic [3:0] t;
        t = WT_NONE;
        if (n >= NID_SPDIF && n <= NID_OUT_LAST) t = WT_OUT;
        if (n == NID_ADC) t = WT_IN;
        if (n >= NID_MIX_1ST && n <= NID_DOWNMIX) t = WT_MIX;
        if (n >= NID_SEL_1ST && n <= NID_SEL_LAST) t = WT_SEL;
        if (n == NID_BEEP) t = WT_BEEP;
        if (n == NID_HP) t = WT_PIN;
        return (t == WT_NONE) ? RESP_ZERO : {8'h00, t, 20'h00000};
    endfunction

    // Main sequence
    initial
    begin
        rstn  = 1'b0;
        spdif = 1'b0;
        swap  = 1'b0;
        mic_l = 1'b1;
        mic_r = 1'b0;
        msel  = 2'h0;
        lsel  = 2'h0;
        repeat (3) @(negedge clk);
        chk("eq_inv", eqi, 32'h1);
        chk("coeff_symmetry", symmetric, 32'h1);
        chk("upmix", upm, 32'h0);
        rstn = 1'b1;
        @(negedge clk);
        // Widget map
        for (i = 0; i <= 8'h1B; i++)
            x(8'(i), {V_GET_PARAM, PARAM_WCAP}, exp_wcap(8'(i)));
        // Single data-in line
        for (i = 2; i <= 4; i++)
        begin
            x(8'(i), {V_SET_SDI, 8'h01}, RESP_ZERO);
            x(8'(i), {V_GET_SDI, 8'h00}, RESP_ZERO);
        end
        // Coefficient store, boundary index, no stepping
        cf(NID_FRONT, 8'h07, {V4_SET_COEF, 16'h1234}, RESP_ZERO);
        cf(NID_FRONT, 8'h08, {V4_SET_COEF, 16'hABCD}, RESP_ZERO);
        cf(NID_FRONT, 8'hFF, {V4_SET_COEF, 16'h5A5A}, RESP_ZERO);
        cf(NID_FRONT, 8'h07, {V4_GET_COEF, 16'h0000}, 32'h1234);
        x(NID_FRONT, {V4_GET_CIDX, 16'h0000}, 32'h7);
        cf(NID_FRONT, 8'hFF, {V4_GET_COEF, 16'h0000}, 32'h5A5A);
        cf(NID_FRONT, 8'h08, {V4_GET_COEF, 16'h0000}, 32'hABCD);
        // Write, index rewrite and read on back-to-back edges
        ctl_u.burst(NID_FRONT, {V4_SET_CIDX, 16'h0042}, {V4_SET_COEF, 16'h3C3C},
            {V4_SET_CIDX, 16'h0042}, {V4_GET_COEF, 16'h0000}, r, ok);
        done(32'h3C3C);
        // Swap widget refuses coefficient verbs
        cf(NID_MICSWAP, 8'h07, {V4_SET_COEF, 16'h1111}, RESP_ZERO);
        cf(NID_MICSWAP, 8'h07, {V4_GET_COEF, 16'h0000}, RESP_ZERO);
        x(NID_MICSWAP, {V4_GET_CIDX, 16'h0000}, RESP_ZERO);
        // Root and function ignore processing state
        for (i = 0; i <= 1; i++)
        begin
            x(8'(i), {V_SET_PST, 8'h81}, RESP_ZERO);
            x(8'(i), {V_GET_PST, 8'h00}, RESP_ZERO);
        end
        // Every front state code; on is kept as benign
        for (i = 0; i < 6; i++)
        begin
            c = codes[i];
            e = (c[6:0] == PST_EQ_ON) ? {c[7], PST_EQ_BEN} : c;
            x(NID_FRONT, {V_SET_PST, c}, RESP_ZERO);
            x(NID_FRONT, {V_GET_PST, 8'h00}, {24'h000000, e});
            chk("eq_inv", eqi, c[6:0] == PST_EQ_OFF);
            chk("coeff_symmetry", symmetric, !c[7]);
        end
        // Downmix mutes: input zero and output only
        x(NID_DOWNMIX, {V4_SET_AMP, 16'h4080}, RESP_ZERO);
        chk("surr_mute", smute, 32'h1);
        x(NID_DOWNMIX, {V4_SET_AMP, 16'h4100}, RESP_ZERO);
        chk("surr_mute", smute, 32'h1);
        x(NID_DOWNMIX, {V4_SET_AMP, 16'h4180}, RESP_ZERO);
        x(NID_DOWNMIX, {V4_GET_AMP, 16'h0001}, RESP_ZERO);
        x(NID_DOWNMIX, {V4_GET_AMP, 16'h0000}, 32'h80);
        x(NID_DOWNMIX, {V4_SET_AMP, 16'h8080}, RESP_ZERO);
        chk("out_mute", omute, 32'h1);
        x(NID_DOWNMIX, {V4_GET_AMP, 16'h8000}, 32'h80);
        x(NID_DOWNMIX, {V4_SET_AMP, 16'h4000}, RESP_ZERO);
        chk("surr_mute", smute, 32'h0);
        // Swap and up-mix in every combination
        for (i = 0; i < 6; i++)
        begin
            swap = i[0];
            c    = 8'(i / 2);
            x(NID_MICSWAP, {V_SET_PST, c}, RESP_ZERO);
            x(NID_MICSWAP, {V_GET_PST, 8'h00}, (c == 8'h00) ? 32'h0 : 32'h1);
            repeat (2) @(negedge clk);
            sel_l = swap ? mic_r : mic_l;
            chk("upmix", upm, c != 8'h00);
            chk("mic_l", ml, sel_l);
            chk("mic_r", mr, (c != 8'h00) ? sel_l : (swap ? mic_l : mic_r));
        end
        // Source selections
        for (i = 0; i < 4; i++)
        begin
            spdif = i[0];
            msel  = 2'(i);
            lsel  = 2'(3 - i);
            repeat (2) @(negedge clk);
            chk("spdif_src", spo, spdif);
            chk("mic_src", mso, msel);
            chk("line_src", lso, lsel);
        end
        // Second reset in mid-run
        rstn = 1'b0;
        @(negedge clk);
        chk("upmix", upm, 32'h0);
        chk("eq_inv", eqi, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
